/* File: hw/acr_chan_status.sv */
// per-channel status register: power-down and output reset of one channel
`timescale 1ns/1ns
`default_nettype none
`include "acr_map.svh"

module acr_chan_status #(
    parameter bit IS_CLOCK = 1'b0
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // write strobe, already qualified by the channel select
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    // state
    output logic            power_down,
    output logic            output_reset,
    output logic [7:0]      status
);
    // clock outputs only take the power-down bit; the output reset stays low
    localparam logic [7:0] WR_MASK = IS_CLOCK ? `ACR_MSK_CLK_STATUS : `ACR_MSK_CHAN_STATUS;

    always_ff @(posedge clk) begin
        if (srst) begin
            status <= `ACR_RST_CHAN_STATUS;
        end else if (wr_en) begin
            status <= wdata & WR_MASK;
        end
    end

    assign power_down   = status[`ACR_BIT_POWER_DOWN];
    assign output_reset = status[`ACR_BIT_OUT_RESET];
endmodule
`default_nettype wire

/* File: hw/acr_map.svh */
// register offsets, field positions, write masks and reset values of the config bank
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// ----------------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------------
`define ACR_OFS_CHAN_INDEX    9'h005
`define ACR_OFS_PATT1_LOW     9'h019
`define ACR_OFS_PATT1_HIGH    9'h01a
`define ACR_OFS_PATT2_LOW     9'h01b
`define ACR_OFS_PATT2_HIGH    9'h01c
`define ACR_OFS_SERIAL_CTRL   9'h021
`define ACR_OFS_CHAN_STATUS   9'h022
`define ACR_OFS_COMMIT        9'h0ff
`define ACR_OFS_OVERRIDE      9'h100
`define ACR_OFS_IO_PULLDOWN   9'h101
`define ACR_OFS_IO_CMODE      9'h102
`define ACR_OFS_SYNC          9'h109

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ACR_RST_CHAN_INDEX    8'h3f
`define ACR_RST_PATT         8'h00
`define ACR_RST_SERIAL_CTRL   8'h32
`define ACR_RST_CHAN_STATUS   8'h00
`define ACR_RST_OVERRIDE      8'h00
`define ACR_RST_IO            8'h00
`define ACR_RST_SYNC          8'h00

// ----------------------------------------------------------------------------
// writable bits (open bits read as zero)
// ----------------------------------------------------------------------------
`define ACR_MSK_CHAN_INDEX    8'h3f
`define ACR_MSK_SERIAL_CTRL   8'hf7
`define ACR_MSK_CHAN_STATUS   8'h03
`define ACR_MSK_CLK_STATUS    8'h01
`define ACR_MSK_OVERRIDE      8'h77
`define ACR_MSK_IO_PULLDOWN   8'h01
`define ACR_MSK_IO_CMODE      8'h08
`define ACR_MSK_SYNC          8'h03

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ACR_BIT_COMMIT        0
`define ACR_BIT_POWER_DOWN    0
`define ACR_BIT_OUT_RESET     1
`define ACR_BIT_SER_LSB_FIRST 7
`define ACR_BIT_SER_FRAME_2X  2
`define ACR_BIT_OVR_ENABLE    6
`define ACR_BIT_IO_PULLDOWN   0
`define ACR_BIT_IO_VCM_PDWN   3
`define ACR_BIT_SYNC_ENABLE   0
`define ACR_BIT_SYNC_NEXT     1

`endif

/* File: hw/acr_pkg.sv */
// shared types of the config register bank
package acr_pkg;
    typedef logic [8:0] acr_addr_t;
    typedef logic [7:0] acr_byte_t;

    // channel order inside the index register: four data channels, then two clocks
    typedef enum logic [2:0] {
        ACR_CH_DATA0 = 3'b000,
        ACR_CH_DATA1 = 3'b001,
        ACR_CH_DATA2 = 3'b010,
        ACR_CH_DATA3 = 3'b011,
        ACR_CH_DCO   = 3'b100,
        ACR_CH_FCO   = 3'b101
    } acr_chan_t;
endpackage

/* File: hw/acr_regbank.sv */
// configuration register bank of a quad serial-output converter
`timescale 1ns/1ns
`default_nettype none
`include "acr_map.svh"

module acr_regbank #(
    parameter int NUM_DATA = 4,
    parameter int NUM_CLK  = 2
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    srst,
    // register access port
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    input  wire acr_pkg::acr_addr_t      reg_addr,
    input  wire acr_pkg::acr_byte_t      reg_wdata,
    output acr_pkg::acr_byte_t           reg_rdata,
    output logic                         reg_rvalid,
    // per-channel controls
    output logic [NUM_DATA-1:0]          chan_power_down,
    output logic [NUM_DATA-1:0]          chan_output_reset,
    output logic [NUM_CLK-1:0]           clk_power_down,
    // user test patterns
    output logic [15:0]                  user_pattern1,
    output logic [15:0]                  user_pattern2,
    // serial output control
    output logic                         serial_lsb_first,
    output logic [2:0]                   serial_lane_mode,
    output logic                         serial_frame_2x,
    output logic [1:0]                   serial_word_bits,
    // committed resolution and rate override
    output logic                         override_enable,
    output logic [1:0]                   override_resolution,
    output logic [2:0]                   override_rate,
    // user i/o and sync
    output logic                         sdio_pulldown_off,
    output logic                         vcm_power_down,
    output logic                         sync_enable,
    output logic                         sync_next_only
);
    import acr_pkg::*;

    localparam int NUM_CH = NUM_DATA + NUM_CLK;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    acr_byte_t channel_index_select;
    acr_byte_t user_pattern1_low_byte;
    acr_byte_t user_pattern1_high_byte;
    acr_byte_t user_pattern2_low_byte;
    acr_byte_t user_pattern2_high_byte;
    acr_byte_t serial_output_control;
    acr_byte_t resolution_rate_override;
    acr_byte_t override_active;
    acr_byte_t io_control_pulldown;
    acr_byte_t io_control_common_mode;
    acr_byte_t multichip_sync_control;

    logic [NUM_CH-1:0] ch_sel;
    logic [NUM_CH-1:0] ch_pdwn;
    logic [NUM_CH-1:0] ch_orst;
    acr_byte_t         ch_status [NUM_CH];
    acr_byte_t         next_rdata;
    logic              status_wr;

    function automatic logic hit(input acr_addr_t ofs);
        hit = reg_wr && (reg_addr == ofs);
    endfunction

    // ------------------------------------------------------------------------
    // global registers, live on the write cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            channel_index_select <= `ACR_RST_CHAN_INDEX;
        end else if (hit(`ACR_OFS_CHAN_INDEX)) begin
            channel_index_select <= reg_wdata & `ACR_MSK_CHAN_INDEX;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            user_pattern1_low_byte  <= `ACR_RST_PATT;
            user_pattern1_high_byte <= `ACR_RST_PATT;
            user_pattern2_low_byte  <= `ACR_RST_PATT;
            user_pattern2_high_byte <= `ACR_RST_PATT;
        end else begin
            if (hit(`ACR_OFS_PATT1_LOW)) begin
                user_pattern1_low_byte <= reg_wdata;
            end
            if (hit(`ACR_OFS_PATT1_HIGH)) begin
                user_pattern1_high_byte <= reg_wdata;
            end
            if (hit(`ACR_OFS_PATT2_LOW)) begin
                user_pattern2_low_byte <= reg_wdata;
            end
            if (hit(`ACR_OFS_PATT2_HIGH)) begin
                user_pattern2_high_byte <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            serial_output_control <= `ACR_RST_SERIAL_CTRL;
        end else if (hit(`ACR_OFS_SERIAL_CTRL)) begin
            serial_output_control <= reg_wdata & `ACR_MSK_SERIAL_CTRL;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            io_control_pulldown    <= `ACR_RST_IO;
            io_control_common_mode <= `ACR_RST_IO;
            multichip_sync_control <= `ACR_RST_SYNC;
        end else begin
            if (hit(`ACR_OFS_IO_PULLDOWN)) begin
                io_control_pulldown <= reg_wdata & `ACR_MSK_IO_PULLDOWN;
            end
            if (hit(`ACR_OFS_IO_CMODE)) begin
                io_control_common_mode <= reg_wdata & `ACR_MSK_IO_CMODE;
            end
            if (hit(`ACR_OFS_SYNC)) begin
                multichip_sync_control <= reg_wdata & `ACR_MSK_SYNC;
            end
        end
    end

    // ------------------------------------------------------------------------
    // override: written value is only staged, commit copies it to the live copy
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            resolution_rate_override <= `ACR_RST_OVERRIDE;
        end else if (hit(`ACR_OFS_OVERRIDE)) begin
            resolution_rate_override <= reg_wdata & `ACR_MSK_OVERRIDE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            override_active <= `ACR_RST_OVERRIDE;
        end else if (hit(`ACR_OFS_COMMIT) && reg_wdata[`ACR_BIT_COMMIT]) begin
            override_active <= resolution_rate_override;
        end
    end

    // ------------------------------------------------------------------------
    // per-channel status, one instance per data and clock channel
    // ------------------------------------------------------------------------
    assign ch_sel = channel_index_select[NUM_CH-1:0];

    // plain decode, not hit(): a port expression only re-evaluates on its own
    // operands, never on the globals that a function reads
    assign status_wr = reg_wr && (reg_addr == `ACR_OFS_CHAN_STATUS);

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        acr_chan_status #(
            .IS_CLOCK (i >= NUM_DATA)
        ) u_status (
            .clk          (clk),
            .srst         (srst),
            .wr_en        (status_wr && ch_sel[i]),
            .wdata        (reg_wdata),
            .power_down   (ch_pdwn[i]),
            .output_reset (ch_orst[i]),
            .status       (ch_status[i])
        );
    end

    assign chan_power_down   = ch_pdwn[NUM_DATA-1:0];
    assign chan_output_reset = ch_orst[NUM_DATA-1:0];
    assign clk_power_down    = ch_pdwn[NUM_CH-1:NUM_DATA];

    // ------------------------------------------------------------------------
    // field outputs
    // ------------------------------------------------------------------------
    assign user_pattern1 = {user_pattern1_high_byte, user_pattern1_low_byte};
    assign user_pattern2 = {user_pattern2_high_byte, user_pattern2_low_byte};

    assign serial_lsb_first = serial_output_control[`ACR_BIT_SER_LSB_FIRST];
    assign serial_lane_mode = serial_output_control[6:4];
    assign serial_frame_2x  = serial_output_control[`ACR_BIT_SER_FRAME_2X];
    assign serial_word_bits = serial_output_control[1:0];

    assign override_enable     = override_active[`ACR_BIT_OVR_ENABLE];
    assign override_resolution = override_active[5:4];
    assign override_rate       = override_active[2:0];

    assign sdio_pulldown_off = io_control_pulldown[`ACR_BIT_IO_PULLDOWN];
    assign vcm_power_down    = io_control_common_mode[`ACR_BIT_IO_VCM_PDWN];
    assign sync_enable       = multichip_sync_control[`ACR_BIT_SYNC_ENABLE];
    assign sync_next_only    = multichip_sync_control[`ACR_BIT_SYNC_NEXT];

    // ------------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------------
    // a local register reads from the lowest selected channel, so software that
    // selects several channels sees one of them, not a merge
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `ACR_OFS_CHAN_INDEX:  next_rdata = channel_index_select;
            `ACR_OFS_PATT1_LOW:   next_rdata = user_pattern1_low_byte;
            `ACR_OFS_PATT1_HIGH:  next_rdata = user_pattern1_high_byte;
            `ACR_OFS_PATT2_LOW:   next_rdata = user_pattern2_low_byte;
            `ACR_OFS_PATT2_HIGH:  next_rdata = user_pattern2_high_byte;
            `ACR_OFS_SERIAL_CTRL: next_rdata = serial_output_control;
            `ACR_OFS_CHAN_STATUS: begin
                for (int k = NUM_CH - 1; k >= 0; k--) begin
                    if (ch_sel[k]) begin
                        next_rdata = ch_status[k];
                    end
                end
            end
            `ACR_OFS_OVERRIDE:    next_rdata = resolution_rate_override;
            `ACR_OFS_IO_PULLDOWN: next_rdata = io_control_pulldown;
            `ACR_OFS_IO_CMODE:    next_rdata = io_control_common_mode;
            `ACR_OFS_SYNC:        next_rdata = multichip_sync_control;
            // the commit bit is an action and unmapped offsets read zero
            default:              next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/acr_host.sv */
// host model driving the register access port
`timescale 1ns/1ns
`default_nettype none
module acr_host (
    // clock
    input  wire logic               clk,
    // register access port
    output logic                    reg_wr,
    output logic                    reg_rd,
    output acr_pkg::acr_addr_t      reg_addr,
    output acr_pkg::acr_byte_t      reg_wdata,
    input  wire acr_pkg::acr_byte_t reg_rdata,
    input  wire logic               reg_rvalid
);
    import acr_pkg::*;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
    end
    // released lines show the inverse, so stale values cannot pass by luck
    task automatic wr(input acr_addr_t a, input acr_byte_t d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input acr_addr_t a, output acr_byte_t d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
    task automatic commit();
        wr(9'h0ff, 8'h01);
    endtask
endmodule
`default_nettype wire

/* File: testbench/acr_regbank_sva.sv */
// assertions on the ports of the config register bank
`timescale 1ns/1ns
`default_nettype none
module acr_regbank_chk #(
    parameter int NUM_DATA = 4,
    parameter int NUM_CLK  = 2
) (
    // clock, reset and access port
    input wire logic                clk,
    input wire logic                srst,
    input wire logic                reg_wr,
    input wire acr_pkg::acr_addr_t  reg_addr,
    input wire acr_pkg::acr_byte_t  reg_wdata,
    // controls
    input wire logic [NUM_DATA-1:0] chan_power_down,
    input wire logic [NUM_DATA-1:0] chan_output_reset,
    input wire logic [NUM_CLK-1:0]  clk_power_down,
    input wire logic [15:0]         user_pattern1,
    input wire logic [2:0]          serial_lane_mode,
    input wire logic                override_enable,
    input wire logic [1:0]          override_resolution,
    input wire logic [2:0]          override_rate
);
    import acr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // own copy of the channel select, so local writes can be predicted
    logic [5:0] sel;
    wire logic  st_wr = reg_wr && reg_addr == 9'h022;
    wire logic  cm_wr = reg_wr && reg_addr == 9'h0ff && reg_wdata[0];
    always_ff @(posedge clk) begin
        if (srst) sel <= 6'h3f;
        else if (reg_wr && reg_addr == 9'h005) sel <= reg_wdata[5:0];
    end
    a_override_hold: assert property (!cm_wr |=> $stable({override_enable,
        override_resolution, override_rate})) else $error("override moved without commit");
    a_commit_loads: assert property (reg_wr && reg_addr == 9'h100 ##1 !reg_wr ##1 cm_wr
        |=> override_rate == $past(reg_wdata[2:0], 3) && override_enable == $past(reg_wdata[6], 3)
        && override_resolution == $past(reg_wdata[5:4], 3)) else $error("commit load wrong");
    a_local_pdown: assert property (st_wr |=> chan_power_down == (($past(sel[3:0])
        & {4{$past(reg_wdata[0])}}) | (~$past(sel[3:0]) & $past(chan_power_down))))
        else $error("data power-down wrong");
    a_local_oreset: assert property (st_wr |=> chan_output_reset == (($past(sel[3:0])
        & {4{$past(reg_wdata[1])}}) | (~$past(sel[3:0]) & $past(chan_output_reset))))
        else $error("data output reset wrong");
    a_clock_pdown: assert property (st_wr |=> clk_power_down == (($past(sel[5:4])
        & {2{$past(reg_wdata[0])}}) | (~$past(sel[5:4]) & $past(clk_power_down))))
        else $error("clock power-down wrong");
    a_clock_other: assert property (!st_wr |=> $stable(clk_power_down))
        else $error("clock output moved");
    a_serial_global: assert property (reg_wr && reg_addr == 9'h021
        |=> serial_lane_mode == $past(reg_wdata[6:4])) else $error("lane mode wrong");
    a_pattern_low: assert property (reg_wr && reg_addr == 9'h019
        |=> user_pattern1 == {$past(user_pattern1[15:8]), $past(reg_wdata)})
        else $error("pattern low byte wrong");
endmodule
bind acr_regbank acr_regbank_chk #(.NUM_DATA(NUM_DATA), .NUM_CLK(NUM_CLK)) i_chk (
    .clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .chan_power_down(chan_power_down), .chan_output_reset(chan_output_reset),
    .clk_power_down(clk_power_down), .user_pattern1(user_pattern1),
    .serial_lane_mode(serial_lane_mode), .override_enable(override_enable),
    .override_resolution(override_resolution), .override_rate(override_rate));
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench of the config register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import acr_pkg::*;
    typedef struct packed { acr_addr_t a; acr_byte_t d; acr_byte_t e; } acr_row_t;
    logic clk, srst, reg_wr, reg_rd, reg_rvalid;
    acr_addr_t reg_addr;
    acr_byte_t reg_wdata, reg_rdata, v;
    logic [3:0] chan_power_down, chan_output_reset;
    logic [1:0] clk_power_down, serial_word_bits, override_resolution;
    logic [15:0] user_pattern1, user_pattern2;
    logic [2:0] serial_lane_mode, override_rate;
    logic serial_lsb_first, serial_frame_2x, override_enable;
    logic sdio_pulldown_off, vcm_power_down, sync_enable, sync_next_only;
    int bad_count = 0;
    int compares = 0;
    acr_row_t rows [0:11] = '{'{9'h019, 8'ha5, 8'ha5}, '{9'h01a, 8'h5a, 8'h5a},
        '{9'h01b, 8'h3c, 8'h3c}, '{9'h01c, 8'hc3, 8'hc3}, '{9'h021, 8'hff, 8'hf7},
        '{9'h101, 8'hff, 8'h01}, '{9'h102, 8'hff, 8'h08}, '{9'h109, 8'hff, 8'h03},
        '{9'h100, 8'hff, 8'h77}, '{9'h0ff, 8'h00, 8'h00}, '{9'h150, 8'hff, 8'h00},
        '{9'h005, 8'hff, 8'h3f}};
    acr_regbank i_dut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .chan_power_down(chan_power_down),
        .chan_output_reset(chan_output_reset), .clk_power_down(clk_power_down),
        .user_pattern1(user_pattern1), .user_pattern2(user_pattern2),
        .serial_lsb_first(serial_lsb_first), .serial_lane_mode(serial_lane_mode),
        .serial_frame_2x(serial_frame_2x), .serial_word_bits(serial_word_bits),
        .override_enable(override_enable), .override_resolution(override_resolution),
        .override_rate(override_rate), .sdio_pulldown_off(sdio_pulldown_off),
        .vcm_power_down(vcm_power_down), .sync_enable(sync_enable),
        .sync_next_only(sync_next_only));
    acr_host i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #20000;
        bad_count++;
        results();
    end
    initial begin
        srst = 1'b1;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        i_host.rd(9'h021, v);
        chk("serial reset", 8'h32, v);
        i_host.rd(9'h022, v);
        chk("status reset", 8'h00, v);
        chk("pattern reset", 16'h0000, user_pattern1);
        foreach (rows[i]) begin
            i_host.wr(rows[i].a, rows[i].d);
            i_host.rd(rows[i].a, v);
            chk("readback", rows[i].e, v);
        end
        chk("pattern1", 16'h5aa5, user_pattern1);
        chk("pattern2", 16'hc33c, user_pattern2);
        chk("io sync", 4'hf,
            {sdio_pulldown_off, vcm_power_down, sync_next_only, sync_enable});
        chk("staged only", 6'h00, {override_enable, override_resolution, override_rate});
        i_host.wr(9'h0ff, 8'h00);
        chk("commit zero", 6'h00, {override_enable, override_resolution, override_rate});
        i_host.commit();
        chk("commit", 6'h3f, {override_enable, override_resolution, override_rate});
        i_host.wr(9'h100, 8'h55);
        chk("restage", 6'h3f, {override_enable, override_resolution, override_rate});
        i_host.commit();
        chk("recommit", 6'h2d, {override_enable, override_resolution, override_rate});
        i_host.wr(9'h005, 8'h05);
        i_host.wr(9'h022, 8'h03);
        chk("local data", 10'h154, {chan_power_down, chan_output_reset, clk_power_down});
        i_host.wr(9'h005, 8'h30);
        i_host.wr(9'h022, 8'h03);
        chk("local clock", 10'h157, {chan_power_down, chan_output_reset, clk_power_down});
        i_host.rd(9'h022, v);
        chk("clock status", 8'h01, v);
        i_host.wr(9'h005, 8'h00);
        i_host.wr(9'h022, 8'h00);
        chk("no select", 10'h157, {chan_power_down, chan_output_reset, clk_power_down});
        i_host.wr(9'h021, 8'h12);
        chk("global", 7'h0a,
            {serial_lsb_first, serial_lane_mode, serial_frame_2x, serial_word_bits});
        @(negedge clk);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        chk("mid reset", 9'h003, {chan_power_down, clk_power_down, serial_lane_mode});
        chk("reset override", 16'h0000, {override_enable, override_resolution, override_rate,
            sdio_pulldown_off, vcm_power_down, sync_next_only, sync_enable});
        chk("reset pattern", 16'h0000, user_pattern2);
        i_host.rd(9'h005, v);
        chk("reset index", 8'h3f, v);
        i_host.rd(9'h100, v);
        chk("reset staged", 8'h00, v);
        results();
    end
endmodule
`default_nettype wire
